// file: include/spm_pkg.sv
/*
 * Shared constants, types and helper functions of the program message parser:
 * character codes, keyword table, unit record and parser states.
 * Assumes the includer compiles this package before the parser and its FIFO.
 */
package spm_pkg;

   // character codes seen on the command stream
   localparam logic [7:0] SPM_CH_NL    = 8'h0A;   // newline_char, sole terminator
   localparam logic [7:0] SPM_CH_COLON = 8'h3A;
   localparam logic [7:0] SPM_CH_SEMI  = 8'h3B;
   localparam logic [7:0] SPM_CH_QMARK = 8'h3F;
   localparam logic [7:0] SPM_CH_SPACE = 8'h20;
   localparam logic [7:0] SPM_CH_DOT   = 8'h2E;
   localparam logic [7:0] SPM_CH_PLUS  = 8'h2B;
   localparam logic [7:0] SPM_CH_MINUS = 8'h2D;
   localparam logic [7:0] SPM_CH_ZERO  = 8'h30;
   localparam logic [7:0] SPM_CH_NINE  = 8'h39;
   localparam logic [7:0] SPM_CH_UC_A  = 8'h41;
   localparam logic [7:0] SPM_CH_UC_Z  = 8'h5A;

   // sizes of the keyword store, hierarchy and parameter capture
   localparam int SPM_KW_CHARS   = 12;
   localparam int SPM_KW_NUM     = 16;
   localparam int SPM_MAX_DEPTH  = 4;
   localparam int SPM_STR_CHARS  = 4;
   localparam int SPM_FIFO_DEPTH = 8;
   localparam int SPM_SHORT_ALL  = 4;   // long forms this short are their own short form
   localparam int SPM_SHORT_VOW  = 3;   // short length when the fourth letter is a vowel
   localparam int SPM_SHORT_CON  = 4;   // short length otherwise

   typedef logic [8*SPM_KW_CHARS-1:0] spm_kw_t;
   typedef logic [3:0]                spm_idx_t;
   typedef logic [1:0]                spm_lvl_t;
   typedef logic [2:0]                spm_depth_t;

   // recognised long forms, right aligned, upper case
   localparam spm_kw_t SPM_KW_TABLE [SPM_KW_NUM] = '{
      spm_kw_t'("STATUS"),    spm_kw_t'("OUTPUT"),  spm_kw_t'("VOLTAGE"),  spm_kw_t'("CURRENT"),
      spm_kw_t'("MEASURE"),   spm_kw_t'("TRIGGER"), spm_kw_t'("LEVEL"),    spm_kw_t'("IMMEDIATE"),
      spm_kw_t'("ENABLE"),    spm_kw_t'("EVENT"),   spm_kw_t'("MODE"),     spm_kw_t'("LIST"),
      spm_kw_t'("PRESET"),    spm_kw_t'("OPERATION"), spm_kw_t'("QUESTIONABLE"), spm_kw_t'("CONDITION")};

   // entries accepted only when fully spelled (bit per table entry)
   localparam logic [SPM_KW_NUM-1:0] SPM_LONG_ONLY_RST = 16'h8000;

   typedef enum logic [1:0] {SPM_PAR_NONE, SPM_PAR_NUM, SPM_PAR_STR} spm_par_t;

   typedef enum logic [2:0] {SPM_ST_START, SPM_ST_KW, SPM_ST_QRY, SPM_ST_PARAM, SPM_ST_DISCARD} spm_state_t;

   // one received character with its end_of_line_flag
   typedef struct packed {
      logic [7:0] ch;
      logic       end_of_line_flag;
   } spm_rx_t;

   // one decoded message unit
   typedef struct packed {
      spm_idx_t [SPM_MAX_DEPTH-1:0] path;    // keyword index per level
      spm_depth_t                   depth;   // number of valid levels
      logic                         query;
      spm_par_t                     kind;
      logic                         neg;
      logic [15:0]                  num;     // integer part of a numeric parameter
      logic [8*SPM_STR_CHARS-1:0]   str;     // first characters of a string parameter
   } spm_unit_t;

   // count of characters in a right aligned keyword
   function automatic int spm_kw_len(spm_kw_t t);
      int n;
      n = 0;
      for (int i = 0; i < SPM_KW_CHARS; i++) begin
         if (t[8*i+:8] != 8'h00) begin
            n = n + 1;
         end
      end
      return n;
   endfunction

   // length of the short form derived from the long form
   function automatic int spm_short_len(spm_kw_t t);
      int         n;
      logic [7:0] c4;
      n  = spm_kw_len(t);
      c4 = 8'h00;
      if (n <= SPM_SHORT_ALL) begin
         return n;
      end
      c4 = t[8*(n-4)+:8];
      if (c4 == "A" || c4 == "E" || c4 == "I" || c4 == "O" || c4 == "U") begin
         return SPM_SHORT_VOW;
      end
      return SPM_SHORT_CON;
   endfunction

endpackage

// file: rtl/spm_fifo.sv
/*
 * Synchronous FIFO with a registered read stage, valid/ready on both sides.
 * Assumes one clock and an active low asynchronous reset shared with its user.
 */
`timescale 1ns/100ps
module spm_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic                  full
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wptr_q, wptr_d, rptr_q, rptr_d;
   logic [CW-1:0]    cnt_q, cnt_d;
   logic [WIDTH-1:0] out_q, out_d;
   logic             vld_q, vld_d;
   logic             push, load;

   // pointer, count and output stage next values
   always_comb begin
      full     = (cnt_q == CW'(DEPTH));
      in_ready = !full;
      push     = in_valid && !full;
      load     = (cnt_q != '0) && (!vld_q || out_ready);
      wptr_d   = wptr_q;
      rptr_d   = rptr_q;
      if (push) begin
         wptr_d = (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + AW'(1);
      end
      if (load) begin
         rptr_d = (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + AW'(1);
      end
      cnt_d = cnt_q + CW'(push) - CW'(load);
      out_d = load ? mem_q[rptr_q] : out_q;
      vld_d = load ? 1'b1 : (vld_q && !out_ready);
   end

   // storage array, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wptr_q] <= in_data;
      end
   end

   // control registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q  <= '0;
         out_q  <= '0;
         vld_q  <= 1'b0;
      end else begin
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         cnt_q  <= cnt_d;
         out_q  <= out_d;
         vld_q  <= vld_d;
      end
   end

   assign out_data  = out_q;
   assign out_valid = vld_q;
endmodule

// file: rtl/spm_parser.sv
/*
 * Character level parser of program messages: keywords, separators, query,
 * parameter and terminator, with the character FIFO in front of it.
 * Assumes characters arrive from logic on SYS_CLK with valid/ready handshake.
 */
// Summary of operation
// [RULE1] short form: all, first four, or three
// [RULE2] wrong truncation of keyword raises error
// [RULE3] controller sends full or exact short form
// [RULE4] keyword matching ignores letter case
// [RULE5] long form accepted; some keywords long only
// [RULE6] colon separates keywords, descends one level
// [RULE7] question mark only after last keyword
// [RULE8] space then numeric or string parameter
// [RULE9] newline or end_of_line_flag ends message
// [RULE10] units then one terminator form message
// [RULE11] controller sends list commands as one message
// [RULE12] line feed is the only terminator
// [RULE13] semicolon splits units, same level kept
// [RULE14] leading colon returns to root
// [RULE15] terminator returns parser to root
// [RULE16] on error discard to terminator, flag
`timescale 1ns/100ps
module spm_parser #(
   parameter logic [spm_pkg::SPM_KW_NUM-1:0] LONG_ONLY = spm_pkg::SPM_LONG_ONLY_RST
) (
   input  wire logic               SYS_CLK,
   input  wire logic               RSTN,
   input  wire logic [7:0]         RX_CHAR,
   input  wire logic               END_OF_LINE_FLAG,
   input  wire logic               RX_VALID,
   output logic                    RX_READY,
   output logic                    UNIT_VALID,
   output spm_pkg::spm_unit_t      UNIT,
   output logic                    ERR_FLAG,
   input  wire logic               ERR_CLR
);
   localparam int N = spm_pkg::SPM_KW_NUM;

   spm_pkg::spm_rx_t    rx_in, rx_out;
   logic                rx_vld, rx_rdy;
   spm_pkg::spm_state_t st_q, st_d;
   spm_pkg::spm_kw_t    buf_q, buf_d;
   logic [3:0]          len_q, len_d;
   spm_pkg::spm_lvl_t   lvl_q, lvl_d;
   spm_pkg::spm_unit_t  cur_q, cur_d, unit_q, unit_d;
   logic [2:0]          slen_q, slen_d;
   logic                frac_q, frac_d, pend_q, pend_d, uv_q, uv_d, err_q, err_d;
   logic [N-1:0]        hit;
   logic                kw_hit, take, act, is_term, bad, emit, record;
   logic [7:0]          ch, cu;
   spm_pkg::spm_idx_t   kw_idx;

   assign rx_in = '{ch: RX_CHAR, end_of_line_flag: END_OF_LINE_FLAG};

   // character buffer ahead of the parser; stalls while a flagged end is pending
   spm_fifo #(
      .WIDTH ($bits(spm_pkg::spm_rx_t)),
      .DEPTH (spm_pkg::SPM_FIFO_DEPTH)
   ) u_fifo (
      .clk       (SYS_CLK),
      .rst_n     (RSTN),
      .in_data   (rx_in),
      .in_valid  (RX_VALID),
      .in_ready  (RX_READY),
      .out_data  (rx_out),
      .out_valid (rx_vld),
      .out_ready (rx_rdy),
      .full      ()
   );

   // keyword comparators, one per table entry
   for (genvar i = 0; i < N; i++) begin : g_kw
      localparam spm_pkg::spm_kw_t T  = spm_pkg::SPM_KW_TABLE[i];
      localparam int               LL = spm_pkg::spm_kw_len(T);
      localparam int               SL = spm_pkg::spm_short_len(T);
      // [RULE1] [RULE5] full or short form
      assign hit[i] = (len_q == 4'(LL) && buf_q == T)
                   || (!LONG_ONLY[i] && len_q == 4'(SL) && buf_q == (T >> (8 * (LL - SL))));
   end

   // lowest matching entry wins
   always_comb begin
      kw_idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (hit[i]) begin
            kw_idx = spm_pkg::spm_idx_t'(i);
         end
      end
      kw_hit = |hit;
   end

   assign rx_rdy = !pend_q;
   assign take   = rx_vld && rx_rdy;
   assign act    = take || pend_q;
   assign ch     = pend_q ? spm_pkg::SPM_CH_NL : rx_out.ch;
   // [RULE4] fold lower case letters to upper case
   assign cu     = (ch >= 8'h61 && ch <= 8'h7A) ? {ch[7:6], 1'b0, ch[4:0]} : ch;

   // parser next state
   always_comb begin
      st_d   = st_q;
      buf_d  = buf_q;
      len_d  = len_q;
      lvl_d  = lvl_q;
      cur_d  = cur_q;
      slen_d = slen_q;
      frac_d = frac_q;
      bad    = 1'b0;
      emit   = 1'b0;
      record = 1'b0;
      // [RULE9] [RULE12] newline or flagged character ends the message
      is_term = act && (ch == spm_pkg::SPM_CH_NL);
      pend_d  = take && rx_out.end_of_line_flag && (rx_out.ch != spm_pkg::SPM_CH_NL);
      if (act) begin
         case (st_q)
            spm_pkg::SPM_ST_START: begin
               cur_d  = '{path: cur_q.path, kind: spm_pkg::SPM_PAR_NONE, default: '0};
               slen_d = '0;
               frac_d = 1'b0;
               buf_d  = '0;
               len_d  = '0;
               if (is_term || cu == spm_pkg::SPM_CH_SPACE) begin
                  st_d = spm_pkg::SPM_ST_START;
               end else if (cu == spm_pkg::SPM_CH_COLON) begin
                  // [RULE14] root specifier
                  lvl_d = '0;
                  st_d  = spm_pkg::SPM_ST_KW;
               end else if (cu >= spm_pkg::SPM_CH_UC_A && cu <= spm_pkg::SPM_CH_UC_Z) begin
                  buf_d = spm_pkg::spm_kw_t'(cu);
                  len_d = 4'd1;
                  st_d  = spm_pkg::SPM_ST_KW;
               end else begin
                  bad = 1'b1;
               end
            end
            spm_pkg::SPM_ST_KW: begin
               if (cu >= spm_pkg::SPM_CH_UC_A && cu <= spm_pkg::SPM_CH_UC_Z) begin
                  bad   = (len_q == 4'(spm_pkg::SPM_KW_CHARS));
                  buf_d = {buf_q[8*spm_pkg::SPM_KW_CHARS-9:0], cu};
                  len_d = len_q + 4'd1;
               end else if (len_q == '0 || !kw_hit) begin
                  // [RULE2] no form matches
                  bad = 1'b1;
               end else begin
                  record = 1'b1;
                  buf_d  = '0;
                  len_d  = '0;
                  if (is_term) begin
                     emit = 1'b1;
                     st_d = spm_pkg::SPM_ST_START;
                  end else begin
                     case (cu)
                        spm_pkg::SPM_CH_COLON: begin
                           // [RULE6] descend one level
                           bad   = (lvl_q == spm_pkg::spm_lvl_t'(spm_pkg::SPM_MAX_DEPTH - 1));
                           lvl_d = lvl_q + 2'd1;
                        end
                        spm_pkg::SPM_CH_QMARK: begin
                           cur_d.query = 1'b1;
                           st_d        = spm_pkg::SPM_ST_QRY;
                        end
                        spm_pkg::SPM_CH_SPACE: st_d = spm_pkg::SPM_ST_PARAM;
                        spm_pkg::SPM_CH_SEMI: begin
                           emit = 1'b1;
                           st_d = spm_pkg::SPM_ST_START;
                        end
                        default: bad = 1'b1;
                     endcase
                  end
               end
            end
            spm_pkg::SPM_ST_QRY: begin
               // [RULE7] only a parameter or unit end may follow the query mark
               if (is_term || cu == spm_pkg::SPM_CH_SEMI) begin
                  emit = 1'b1;
                  st_d = spm_pkg::SPM_ST_START;
               end else if (cu == spm_pkg::SPM_CH_SPACE) begin
                  st_d = spm_pkg::SPM_ST_PARAM;
               end else begin
                  bad = 1'b1;
               end
            end
            spm_pkg::SPM_ST_PARAM: begin
               // [RULE8] numeric or string parameter
               if (is_term || cu == spm_pkg::SPM_CH_SEMI) begin
                  emit = 1'b1;
                  st_d = spm_pkg::SPM_ST_START;
               end else if (cu == spm_pkg::SPM_CH_SPACE) begin
                  st_d = spm_pkg::SPM_ST_PARAM;
               end else if (cur_q.kind != spm_pkg::SPM_PAR_STR && cu >= spm_pkg::SPM_CH_ZERO
                            && cu <= spm_pkg::SPM_CH_NINE) begin
                  cur_d.kind = spm_pkg::SPM_PAR_NUM;
                  if (!frac_q) begin
                     cur_d.num = 16'(cur_q.num * 16'd10) + {8'h00, cu - spm_pkg::SPM_CH_ZERO};
                  end
               end else if (cur_q.kind != spm_pkg::SPM_PAR_STR && cu == spm_pkg::SPM_CH_DOT) begin
                  cur_d.kind = spm_pkg::SPM_PAR_NUM;
                  frac_d     = 1'b1;
               end else if (cur_q.kind == spm_pkg::SPM_PAR_NONE
                            && (cu == spm_pkg::SPM_CH_PLUS || cu == spm_pkg::SPM_CH_MINUS)) begin
                  cur_d.kind = spm_pkg::SPM_PAR_NUM;
                  cur_d.neg  = (cu == spm_pkg::SPM_CH_MINUS);
               end else if (cur_q.kind != spm_pkg::SPM_PAR_NUM && ((cu >= spm_pkg::SPM_CH_UC_A
                            && cu <= spm_pkg::SPM_CH_UC_Z) || (cur_q.kind == spm_pkg::SPM_PAR_STR
                            && cu >= spm_pkg::SPM_CH_ZERO && cu <= spm_pkg::SPM_CH_NINE))) begin
                  cur_d.kind = spm_pkg::SPM_PAR_STR;
                  if (slen_q != 3'(spm_pkg::SPM_STR_CHARS)) begin
                     cur_d.str = {cur_q.str[8*spm_pkg::SPM_STR_CHARS-9:0], cu};
                     slen_d    = slen_q + 3'd1;
                  end
               end else begin
                  bad = 1'b1;
               end
            end
            spm_pkg::SPM_ST_DISCARD: begin
               // [RULE16] drop characters until the terminator
               if (is_term) begin
                  st_d = spm_pkg::SPM_ST_START;
               end
            end
            default: bad = 1'b1;
         endcase
         if (record) begin
            cur_d.path[lvl_q] = kw_idx;
            cur_d.depth       = spm_pkg::spm_depth_t'(lvl_q) + 3'd1;
         end
         if (bad) begin
            emit  = 1'b0;
            buf_d = '0;
            len_d = '0;
            st_d  = is_term ? spm_pkg::SPM_ST_START : spm_pkg::SPM_ST_DISCARD;
         end
         // [RULE15] back to root at every terminator
         if (is_term) begin
            lvl_d = '0;
         end
      end
      // [RULE10] [RULE13] a unit is complete at semicolon or terminator
      uv_d   = emit;
      unit_d = emit ? cur_d : unit_q;
      // [RULE16] sticky error, a new error wins over the clear
      err_d  = bad || (err_q && !ERR_CLR);
   end

   // parser registers
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_q   <= spm_pkg::SPM_ST_START;
         buf_q  <= '0;
         len_q  <= '0;
         lvl_q  <= '0;
         cur_q  <= '0;
         slen_q <= '0;
         frac_q <= 1'b0;
         pend_q <= 1'b0;
         uv_q   <= 1'b0;
         unit_q <= '0;
         err_q  <= 1'b0;
      end else begin
         st_q   <= st_d;
         buf_q  <= buf_d;
         len_q  <= len_d;
         lvl_q  <= lvl_d;
         cur_q  <= cur_d;
         slen_q <= slen_d;
         frac_q <= frac_d;
         pend_q <= pend_d;
         uv_q   <= uv_d;
         unit_q <= unit_d;
         err_q  <= err_d;
      end
   end

   assign UNIT_VALID = uv_q;
   assign UNIT       = unit_q;
   assign ERR_FLAG   = err_q;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);

   a_term_root: assert property (is_term |=> lvl_q == '0) // [RULE15]
      else $error("terminator did not return to root");
   a_root_colon: assert property (take && st_q == spm_pkg::SPM_ST_START && ch == spm_pkg::SPM_CH_COLON // [RULE14]
                                  && !rx_out.end_of_line_flag |=> lvl_q == '0 && st_q == spm_pkg::SPM_ST_KW)
      else $error("root colon not honoured");
   a_colon_descend: assert property (take && st_q == spm_pkg::SPM_ST_KW && ch == spm_pkg::SPM_CH_COLON // [RULE6]
                                     && kw_hit && len_q != '0 && lvl_q != 2'd3 |=> lvl_q == $past(lvl_q) + 2'd1)
      else $error("keyword separator did not descend");
   a_query_last: assert property (take && st_q == spm_pkg::SPM_ST_QRY && ch == spm_pkg::SPM_CH_COLON // [RULE7]
                                  |=> err_q && !uv_q)
      else $error("keyword after query accepted");
   a_nomatch_err: assert property (take && st_q == spm_pkg::SPM_ST_KW && len_q != '0 && !kw_hit // [RULE2]
                                   && !(cu >= spm_pkg::SPM_CH_UC_A && cu <= spm_pkg::SPM_CH_UC_Z) |=> err_q)
      else $error("unknown keyword not flagged");
   a_case_fold: assert property (take && ch == 8'h61 |-> cu == 8'h41) // [RULE4]
      else $error("lower case not folded");
   a_unit_term: assert property (is_term && st_q == spm_pkg::SPM_ST_KW && kw_hit && len_q != '0 // [RULE10]
                                 |=> uv_q && UNIT.path[$past(lvl_q)] == $past(kw_idx))
      else $error("terminated unit not delivered");
   a_eol_end: assert property (take && rx_out.end_of_line_flag && rx_out.ch != spm_pkg::SPM_CH_NL // [RULE9]
                               |=> pend_q && !take ##1 lvl_q == '0 && st_q != spm_pkg::SPM_ST_DISCARD)
      else $error("flagged character did not end message");
   a_discard_hold: assert property (st_q == spm_pkg::SPM_ST_DISCARD && !is_term // [RULE16]
                                    |=> st_q == spm_pkg::SPM_ST_DISCARD && !uv_q)
      else $error("discard left early");
   a_num_param: assert property (act && st_q == spm_pkg::SPM_ST_PARAM && cur_q.kind == spm_pkg::SPM_PAR_NONE // [RULE8]
                                 && ch == spm_pkg::SPM_CH_ZERO |=> cur_q.kind == spm_pkg::SPM_PAR_NUM)
      else $error("numeric parameter not recognised");

   c_query_unit: cover property (uv_q && UNIT.query);
   c_str_param: cover property (uv_q && UNIT.kind == spm_pkg::SPM_PAR_STR);
   c_error: cover property ($rose(err_q));
   c_two_units: cover property (uv_q ##[1:20] uv_q);
endmodule

// file: tb/spm_ctrl_model.sv
/*
 * Controller model: sends program messages one character at a time.
 * Assumes the parser samples valid/ready on the rising edge of clk.
 */
`timescale 1ns/100ps
module spm_ctrl_model (
   input  wire logic       clk,
   input  wire logic       rdy,
   output logic [7:0]      ch,
   output logic            end_of_line_flag,
   output logic            vld
);
   int stalls;

   // idle bus after time zero
   initial begin
      ch     = 8'h00;
      end_of_line_flag    = 1'b0;
      vld    = 1'b0;
      stalls = 0;
   end

   // released lines show the inverse of the last value
   task automatic release_bus();
      vld = 1'b0;
      ch  = ~ch;
      end_of_line_flag = ~end_of_line_flag;
   endtask

   // whole units then terminator
   // fl: 0 no flag, 1 flag on last char, 2 flag on every char
   task automatic send_msg(input string s, input int fl, input int gap);
      for (int i = 0; i < s.len(); i++) begin
         @(negedge clk);
         ch  = s[i];
         end_of_line_flag = (fl == 2) || (fl == 1 && i == s.len() - 1);
         vld = 1'b1;
         while (rdy !== 1'b1) begin
            stalls++;
            @(negedge clk);
         end
         @(posedge clk);
         if (gap > 0 || i == s.len() - 1) begin
            @(negedge clk);
            release_bus();
            repeat (gap) @(negedge clk);
         end
      end
   endtask
endmodule

// file: tb/scpi_message_parser_tb_top.sv
/*
 * Self-checking bench of the message parser with a controller model.
 * Assumes the parser package is compiled first.
 */
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
$display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module scpi_message_parser_tb_top;
   logic               clk;
   logic               rstn;
   logic               err_clr;
   logic               rx_ready;
   logic               unit_valid;
   spm_pkg::spm_unit_t unit;
   logic               err_flag;
   logic [7:0]         ch;
   logic               end_of_line_flag;
   logic               vld;
   int                 err_count;
   int                 total_checks;
   spm_pkg::spm_unit_t uq[$];

   spm_parser DUT (.SYS_CLK(clk), .RSTN(rstn), .RX_CHAR(ch), .END_OF_LINE_FLAG(end_of_line_flag), .RX_VALID(vld),
      .RX_READY(rx_ready), .UNIT_VALID(unit_valid), .UNIT(unit), .ERR_FLAG(err_flag), .ERR_CLR(err_clr));
   spm_ctrl_model model (.clk(clk), .rdy(rx_ready), .ch(ch), .end_of_line_flag(end_of_line_flag), .vld(vld));

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // collect every delivered unit
   always @(posedge clk) begin
      if (unit_valid === 1'b1) begin
         uq.push_back(unit);
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // send one message and count the units it yields
   task automatic run(input string s, input int fl, input int gap, input int n);
      uq.delete();
      model.send_msg(s, fl, gap);
      for (int i = 0; i < 80 && uq.size() < n; i++) @(posedge clk);
      repeat (10) @(posedge clk);
      @(negedge clk);
      `CHK(uq.size(), n)
   endtask

   // compare the oldest unit with the expected fields
   task automatic chk_unit(input logic [15:0] p, input int d, input logic qy, input spm_pkg::spm_par_t k,
      input logic [15:0] n, input logic [31:0] s);
      spm_pkg::spm_unit_t u;
      `CHK(uq.size() > 0, 1'b1)
      if (uq.size() == 0) return;
      u = uq.pop_front();
      `CHK(u.depth, 3'(d))
      `CHK(u.query, qy)
      `CHK(u.kind, k)
      for (int i = 0; i < d; i++) `CHK(u.path[i], p[4*i+:4])
      if (k == spm_pkg::SPM_PAR_NUM) `CHK(u.num, n)
      if (k == spm_pkg::SPM_PAR_STR) `CHK(u.str, s)
   endtask

   task automatic t_forms();
      run("volt:LEV:imm 16\n", 0, 0, 1);
      chk_unit(16'h0762, 3, 1'b0, spm_pkg::SPM_PAR_NUM, 16'h0010, 32'h0);
      run("Measure:CURRent?\n", 0, 2, 1);
      chk_unit(16'h0034, 2, 1'b1, spm_pkg::SPM_PAR_NONE, 16'h0, 32'h0);
      run("CURR 012.5;VOLT -7\n", 0, 0, 2);
      `CHK(uq[0].neg, 1'b0)
      `CHK(uq[1].neg, 1'b1)
      chk_unit(16'h0003, 1, 1'b0, spm_pkg::SPM_PAR_NUM, 16'h000C, 32'h0);
      chk_unit(16'h0002, 1, 1'b0, spm_pkg::SPM_PAR_NUM, 16'h0007, 32'h0);
      $display("test forms done");
   endtask

   task automatic t_units();
      run("STAT:OPER?;PRES\n", 0, 0, 2);
      chk_unit(16'h00D0, 2, 1'b1, spm_pkg::SPM_PAR_NONE, 16'h0, 32'h0);
      chk_unit(16'h00C0, 2, 1'b0, spm_pkg::SPM_PAR_NONE, 16'h0, 32'h0);
      run(":MEAS:VOLT?;:OUTP ON\n", 0, 0, 2);
      chk_unit(16'h0024, 2, 1'b1, spm_pkg::SPM_PAR_NONE, 16'h0, 32'h0);
      chk_unit(16'h0001, 1, 1'b0, spm_pkg::SPM_PAR_STR, 16'h0, 32'h0000_4F4E);
      $display("test units done");
   endtask

   task automatic t_end();
      run("STAT:OPER\n", 0, 0, 1);
      chk_unit(16'h00D0, 2, 1'b0, spm_pkg::SPM_PAR_NONE, 16'h0, 32'h0);
      run("PRES\n", 0, 0, 1);
      chk_unit(16'h000C, 1, 1'b0, spm_pkg::SPM_PAR_NONE, 16'h0, 32'h0);
      run("TRIG", 1, 0, 1);
      chk_unit(16'h0005, 1, 1'b0, spm_pkg::SPM_PAR_NONE, 16'h0, 32'h0);
      $display("test end done");
   endtask

   task automatic t_err();
      string bad[6];
      bad = '{"ENABL\n", "IMME 3\n", "COND\n", "MODE?:LIST\n",
              "STAT:OPER:EVEN:MODE:LIST\n", "QUESTIONABLEX\n"};
      foreach (bad[i]) begin
         run(bad[i], 0, 0, 0);
         `CHK(err_flag, 1'b1)
         @(negedge clk);
         err_clr = 1'b1;
         @(negedge clk);
         err_clr = 1'b0;
         `CHK(err_flag, 1'b0)
      end
      run("MODE;ENABL;LIST\n", 0, 0, 1);
      chk_unit(16'h000A, 1, 1'b0, spm_pkg::SPM_PAR_NONE, 16'h0, 32'h0);
      `CHK(err_flag, 1'b1)
      $display("test errors done");
   endtask

   // flagged spaces each cost a stall cycle, so the buffer fills
   task automatic t_fifo();
      model.stalls = 0;
      run("                        ", 2, 0, 0);
      `CHK(model.stalls > 0, 1'b1)
      `CHK(rx_ready, 1'b1)
      run("MODE?\n", 0, 0, 1);
      chk_unit(16'h000A, 1, 1'b1, spm_pkg::SPM_PAR_NONE, 16'h0, 32'h0);
      $display("test buffer done");
   endtask

   // reset, then the scenarios
   initial begin
      rstn         = 1'b0;
      err_clr      = 1'b0;
      err_count    = 0;
      total_checks = 0;
      repeat (6) @(posedge clk);
      `CHK(rx_ready, 1'b1)
      `CHK(unit_valid, 1'b0)
      `CHK(err_flag, 1'b0)
      @(negedge clk);
      rstn = 1'b1;
      t_forms();
      t_units();
      t_end();
      t_err();
      t_fifo();
      final_report();
   end

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      final_report();
   end
endmodule
